//--- rtl/line_terminal_multiplexer.v
// Line terminal multiplexer: arbitration between terminal positions and one channel
// Functional notes
// - Size is 4, 8, 16, 32 or 64 positions, half input, half output.
// - Each terminal takes one position, input or output, never both.
// - Requests arrive in any order or all at once; one is chosen automatically.
// - The winning position's identifier goes to the channel with its data.
// - Dial-out terminal sits on an output position, four-bit parallel code, no data.
// - Asynchronous serial characters are framed by start and stop bits.
// - Synchronous lines insert timing characters between data at fixed intervals.
// - Timing-signal mode moves eight-bit parallel characters with a presence strobe.
`timescale 1ns/1ns
`default_nettype none
`include "line_mux_regs.vh"

module line_terminal_multiplexer #(
	parameter POSITIONS = `LM_POSITIONS_DEF,
	parameter CW        = `LM_CHAR_W,
	parameter IW        = 6
) (
	input  wire                      ref_clk_in,
	input  wire                      sys_rst_in,
	// Terminal side: input positions hand characters in
	input  wire [POSITIONS/2-1:0]    in_req_in,
	input  wire [POSITIONS/2*CW-1:0] in_char_in,
	// Terminal side: output positions ask for characters
	input  wire [POSITIONS/2-1:0]    out_req_in,
	input  wire [POSITIONS/2*2-1:0]  out_mode_in,
	output reg  [POSITIONS/2-1:0]    out_strobe_out,
	output reg  [CW-1:0]             out_char_out,
	// Channel side
	output wire                      chan_valid_out,
	output reg                       chan_is_input_out,
	output reg  [IW-1:0]             chan_pos_out,
	output reg  [CW-1:0]             chan_data_out,
	input  wire                      chan_ack_in,
	input  wire [CW-1:0]             chan_wdata_in
);

	localparam HALF = POSITIONS / 2;
	localparam NALL = POSITIONS;

	// One-hot arbiter states
	localparam ST_IDLE  = 2'b01;
	localparam ST_GRANT = 2'b10;

	reg  [1:0]      state;
	reg  [HALF-1:0] in_req_s1;
	reg  [HALF-1:0] in_req_s2;
	reg  [HALF-1:0] out_req_s1;
	reg  [HALF-1:0] out_req_s2;
	reg  [HALF-1:0] in_req_prev;
	reg  [HALF-1:0] out_req_prev;
	reg  [HALF*CW-1:0] in_char_s1;
	reg  [HALF*CW-1:0] in_char_s2;
	reg  [HALF*2-1:0]  out_mode_s1;
	reg  [HALF*2-1:0]  out_mode_s2;
	reg  [NALL-1:0] pending;
	reg  [NALL-1:0] clr_mask;
	wire            pick_any;
	wire [IW-1:0]   pick_idx;
	wire [NALL-1:0] req_rise;
	genvar          g;

	// Dial-out positions keep only the low code bits of a character
	function [CW-1:0] dial_code;
		input [CW-1:0] ch;
		begin
			dial_code = {{(CW - `LM_DIAL_W){1'b0}}, ch[`LM_DIAL_W-1:0]};
		end
	endfunction

	// Character handed to an output terminal, chosen by its line mode
	// Framing and fill characters stay in the terminal, so the channel word is passed whole except to dial-out positions
	function [CW-1:0] char_for_mode;
		input [1:0]    mode;
		input [CW-1:0] ch;
		begin
			case (mode)
			`LM_MODE_ASYNC: begin
				char_for_mode = ch; // Terminal adds start and stop bits
			end
			`LM_MODE_SYNC: begin
				char_for_mode = ch; // Terminal inserts timing characters
			end
			`LM_MODE_TIMING: begin
				char_for_mode = ch; // Parallel character, marked by the strobe
			end
			`LM_MODE_DIAL: begin
				char_for_mode = dial_code(ch); // Dialling code only, no data
			end
			default: char_for_mode = ch;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Requests come from terminal pins, so two stages before use
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			in_req_s1    <= {HALF{1'b0}};
			in_req_s2    <= {HALF{1'b0}};
			out_req_s1   <= {HALF{1'b0}};
			out_req_s2   <= {HALF{1'b0}};
			in_req_prev  <= {HALF{1'b0}};
			out_req_prev <= {HALF{1'b0}};
		end else begin
			in_req_s1    <= in_req_in;
			in_req_s2    <= in_req_s1;
			out_req_s1   <= out_req_in;
			out_req_s2   <= out_req_s1;
			in_req_prev  <= in_req_s2;
			out_req_prev <= out_req_s2;
		end
	end

	// ----------------------------------------
	// Terminal data synchronisers
	// ----------------------------------------
	// Characters and modes ride the same two stages as the requests, so a
	// character is already settled here when its request edge reaches the latch
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			in_char_s1  <= {HALF*CW{1'b0}};
			in_char_s2  <= {HALF*CW{1'b0}};
			out_mode_s1 <= {HALF*2{1'b0}};
			out_mode_s2 <= {HALF*2{1'b0}};
		end else begin
			in_char_s1  <= in_char_in;
			in_char_s2  <= in_char_s1;
			out_mode_s1 <= out_mode_in;
			out_mode_s2 <= out_mode_s1;
		end
	end

	// ----------------------------------------
	// Rising-edge detect, one per position
	// ----------------------------------------
	// A level that stays high does not re-arm; only a fresh edge counts
	// Low half are input positions, high half output positions
	generate
		for (g = 0; g < HALF; g = g + 1) begin : g_edge
			assign req_rise[g]        = in_req_s2[g] & ~in_req_prev[g];
			assign req_rise[HALF + g] = out_req_s2[g] & ~out_req_prev[g];
		end
	endgenerate

	// ----------------------------------------
	// Pending request latch
	// ----------------------------------------
	// Low half are input positions, high half output positions
	always @* begin
		clr_mask = {NALL{1'b0}};
		if (state == ST_GRANT && chan_ack_in) begin
			clr_mask[{chan_is_input_out ? 1'b0 : 1'b1, chan_pos_out[IW-2:0]}] = 1'b1;
		end
	end

	// A new rising request wins over a clear in the same cycle
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pending <= {NALL{1'b0}};
		end else begin
			pending <= (pending & ~clr_mask) | req_rise;
		end
	end

	// Lowest index among all pending positions
	prio_pick #(
		.N  (NALL),
		.IW (IW)
	) u_pick (
		.req_in  (pending),
		.any_out (pick_any),
		.idx_out (pick_idx)
	);

	assign chan_valid_out = (state == ST_GRANT);

	// ----------------------------------------
	// Grant state machine
	// ----------------------------------------
	// Grant is frozen until the channel acknowledges
	always @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state             <= ST_IDLE;
			chan_is_input_out <= 1'b0;
			chan_pos_out      <= {IW{1'b0}};
			chan_data_out     <= {CW{1'b0}};
			out_strobe_out    <= {HALF{1'b0}};
			out_char_out      <= {CW{1'b0}};
		end else begin
			out_strobe_out <= {HALF{1'b0}};
			case (state)
			ST_IDLE: begin
				if (pick_any && !clr_mask[pick_idx]) begin
					state             <= ST_GRANT;
					chan_is_input_out <= ~pick_idx[IW-1];
					// Identifier of the winner
					chan_pos_out      <= {1'b0, pick_idx[IW-2:0]};
					chan_data_out     <= pick_idx[IW-1] ? {CW{1'b0}}
						: in_char_s2[pick_idx[IW-2:0]*CW +: CW];
				end
			end
			ST_GRANT: begin
				if (chan_ack_in) begin
					state <= ST_IDLE;
					if (!chan_is_input_out) begin
						// Line mode decides what reaches the terminal
						out_char_out <= char_for_mode(
							out_mode_s2[chan_pos_out[IW-2:0]*2 +: 2], chan_wdata_in);
						// Presence strobe for the position
						out_strobe_out[chan_pos_out[IW-2:0]] <= 1'b1;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule // line_terminal_multiplexer

`default_nettype wire

//--- rtl/line_mux_regs.vh
// Constants for the line terminal multiplexer
`ifndef LINE_MUX_REGS_VH
`define LINE_MUX_REGS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define LM_POSITIONS_DEF   64
`define LM_CHAR_W          8
`define LM_DIAL_W          4

// ----------------------------------------
// Mode encodings per position
// ----------------------------------------
`define LM_MODE_ASYNC      2'h0
`define LM_MODE_SYNC       2'h1
`define LM_MODE_TIMING     2'h2
`define LM_MODE_DIAL       2'h3

// ----------------------------------------
// Line timing
// ----------------------------------------
`define LM_CLK_HZ          20000000
`define LM_SYNC_MIN_BPS    2000
`define LM_SYNC_MAX_BPS    4800
`define LM_SYNC_CHAR_GAP   16

`endif

//--- rtl/prio_pick.v
// Fixed priority selector, lowest index wins
`timescale 1ns/1ns
`default_nettype none

module prio_pick #(
	parameter N  = 64,
	parameter IW = 6
) (
	input  wire [N-1:0]  req_in,
	output reg           any_out,
	output reg  [IW-1:0] idx_out
);

	integer i;

	// ----------------------------------------
	// Scan from the top so the lowest hit is kept
	// ----------------------------------------
	always @* begin
		any_out = 1'b0;
		idx_out = {IW{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req_in[i]) begin
				any_out = 1'b1;
				idx_out = i[IW-1:0];
			end
		end
	end

endmodule // prio_pick

`default_nettype wire

//--- verif/ltm_chk.sv
// Grant and strobe checks at the multiplexer ports
`timescale 1ns/1ns
`default_nettype none
module ltm_chk #(
	parameter POSITIONS = 8,
	parameter IW        = 3
) (
	input wire logic                   ref_clk_in,
	input wire logic                   sys_rst_in,
	input wire logic                   chan_valid_out,
	input wire logic                   chan_ack_in,
	input wire logic                   chan_is_input_out,
	input wire logic [IW-1:0]          chan_pos_out,
	input wire logic [POSITIONS/2-1:0] in_req_in,
	input wire logic [POSITIONS/2-1:0] out_req_in,
	input wire logic [POSITIONS/2-1:0] out_strobe_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	grant_hold_a: assert property (chan_valid_out && !chan_ack_in |=>
		chan_valid_out && $stable(chan_pos_out)) else $error("grant moved");
	ack_gap_a: assert property (chan_valid_out && chan_ack_in |=> !chan_valid_out)
		else $error("no idle cycle");
	strobe_pos_a: assert property (chan_valid_out && chan_ack_in && !chan_is_input_out
		|=> out_strobe_out == 1 << $past(chan_pos_out)) else $error("bad strobe");
	top_first_a: assert property ($rose(in_req_in[0]) |-> ##[3:30]
		chan_valid_out && chan_is_input_out && chan_pos_out == 0) else $error("lost");
	pos_range_a: assert property (chan_valid_out |-> chan_pos_out < POSITIONS/2)
		else $error("bad position");
	strobe_cause_a: assert property (out_strobe_out != 0 |->
		$past(chan_valid_out && chan_ack_in && !chan_is_input_out)) else $error("stray strobe");
	out_served_a: assert property ($rose(out_req_in[0]) |-> ##[3:60]
		chan_valid_out && !chan_is_input_out && chan_pos_out == 0) else $error("output lost");
endmodule // ltm_chk
bind line_terminal_multiplexer ltm_chk #(.POSITIONS(POSITIONS), .IW(IW)) chk (
	.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .chan_valid_out(chan_valid_out),
	.chan_ack_in(chan_ack_in), .chan_is_input_out(chan_is_input_out),
	.chan_pos_out(chan_pos_out), .in_req_in(in_req_in), .out_req_in(out_req_in),
	.out_strobe_out(out_strobe_out));
`default_nettype wire

//--- verif/chan_model.sv
// Processor channel model: acks each grant, fast or slow
`timescale 1ns/1ns
`default_nettype none
module chan_model (
	input  wire logic       clk_in, slow_in, valid_in,
	input  wire logic [2:0] pos_in,
	output var logic        ack_out,
	output var logic [7:0]  wdata_out
);
	logic [1:0] wait_cnt;
	initial ack_out = 1'b0;
	// One-cycle ack; data inverted once taken so stale values show
	always @(posedge clk_in) begin
		wait_cnt <= valid_in ? wait_cnt + 2'h1 : 2'h0;
		ack_out <= valid_in && !ack_out && (!slow_in || wait_cnt == 2'h3);
		wdata_out <= ack_out ? ~wdata_out : 8'ha0 | pos_in;
	end
endmodule // chan_model
`default_nettype wire

//--- verif/line_terminal_multiplexer_test.sv
// Self-checking bench for the line terminal multiplexer
`timescale 1ns/1ns
`default_nettype none
module line_terminal_multiplexer_test;
	logic        clk = 0, rst = 1, slow = 0, ack, valid, is_in;
	logic [3:0]  ireq = 0, oreq = 0, strobe;
	logic [31:0] ichar = 0, seed = 92;
	logic [7:0]  omode = 8'he4, ochar, data, wdata;
	logic [2:0]  pos;
	logic [11:0] gq[$], sq[$];
	int          bad_count = 0, n_checks = 0;
	line_terminal_multiplexer #(.POSITIONS(8), .IW(3)) DUT (.ref_clk_in(clk),
		.sys_rst_in(rst), .in_req_in(ireq), .in_char_in(ichar), .out_req_in(oreq),
		.out_mode_in(omode), .out_strobe_out(strobe), .out_char_out(ochar),
		.chan_valid_out(valid), .chan_is_input_out(is_in), .chan_pos_out(pos),
		.chan_data_out(data), .chan_ack_in(ack), .chan_wdata_in(wdata));
	chan_model partner (.clk_in(clk), .slow_in(slow), .valid_in(valid), .pos_in(pos),
		.ack_out(ack), .wdata_out(wdata));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic cmp(input string what, input logic [11:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_grant(input logic [11:0] got);
		cmp("grant", gq.pop_front(), got);
	endtask
	task automatic cmp_strobe(input logic [11:0] got);
		cmp("strobe", sq.pop_front(), got);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial forever #25 clk = ~clk;
	initial begin
		#200000 bad_count++;
		end_of_test;
	end
	// Oldest note against each grant and strobe
	always @(posedge clk) begin
		if (valid && ack) cmp_grant({is_in, pos, data});
		if (|strobe) cmp_strobe({strobe, ochar});
	end
	// All positions at once, then a random set against a slow channel
	initial begin
		repeat (4) @(negedge clk);
		rst = 0;
		for (int r = 0; r < 2; r++) begin
			@(negedge clk);
			seed = xs(seed);
			ichar = seed;
			seed = xs(seed);
			ireq = r ? seed[3:0] : 4'hf;
			oreq = r ? seed[7:4] : 4'hf;
			slow = r[0];
			for (int i = 0; i < 4; i++) if (ireq[i]) gq.push_back({1'b1, 3'(i), ichar[i*8+:8]});
			for (int i = 0; i < 4; i++) if (oreq[i]) begin
				gq.push_back({1'b0, 3'(i), 8'h0});
				sq.push_back({4'(1 << i), (omode[i*2+:2] == 2'h3 ? 8'h0 : 8'ha0) | 8'(i)});
			end
			repeat (3) @(negedge clk);
			ireq = 0;
			oreq = 0;
			repeat (80) @(negedge clk);
		end
		// Every noted grant and strobe must have been seen
		cmp("queued", 12'h0, 12'(gq.size() + sq.size()));
		end_of_test;
	end
endmodule // line_terminal_multiplexer_test
`default_nettype wire
